/* hw/duc_top.sv */
// How it works
// [R1] bit 0 of the span register picks a range of zero to reference (0) or twice it (1).
// [R2] bit 0 of the enable register turns the converter off (0) or on (1).
// [R3] with pin toggle on, a falling strobe edge loads the first stage, a rising the second.
// [R4] when pin toggle and pin load are both on, toggle behaviour wins and load is ignored.
// [R5] pin toggling needs bit 0 of the toggle mask and the pin set up for converter use.
// [R6] with pin load on and the pin set up, a falling strobe edge loads the first stage.
// [R7] writing the direct code field updates the converter code at once.
// [R8] writing the alternate select loads the first stage on 0 and the second on 1.
// [R9] writing 1 to the soft load strobe loads the first stage; the bit then self-clears.
// [R10] the first stage register holds a 12-bit code in bits 11 to 0.
// [R11] the second stage register holds a 12-bit code moved by a rising toggle edge or by writing 1 to the alternate select.
// [R12] every register resets to zero, so the converter is off and all codes are zero.
// [R13] each 16-bit register has its low byte on lane 0 and its high byte on lane 1.
// [R14] one code register follows the most recent load source and holds while disabled.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module duc_top
   import duc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // auxiliary strobe pin and its function setting
   input wire logic aux_strobe_pin_i,
   input wire logic aux_pin_function_sel_i,
   // converter controls
   output logic [CODE_W-1:0] dac_code_o,
   output logic dac_enable_o,
   output logic dac_span_o
);
   duc_regs_t st;
   duc_regs_t next_st;

   logic pin_rise;
   logic pin_fall;
   logic load_req;
   logic [CODE_W-1:0] load_code;
   logic access;
   logic wr_now;
   logic [9:0] idx;
   logic mapped;
   // one hit per register index
   logic hit_span;
   logic hit_enable;
   logic hit_tog_mask;
   logic hit_ld_mask;
   logic hit_direct;
   logic hit_soft_alt;
   logic hit_soft_ld;
   logic hit_stage_a;
   logic hit_stage_b;
   // committed write per register
   logic wr_span;
   logic wr_enable;
   logic wr_tog_mask;
   logic wr_ld_mask;
   logic wr_direct;
   logic wr_soft_alt;
   logic wr_soft_ld;
   logic wr_stage_a;
   logic wr_stage_b;
   logic [15:0] wr_word;
   logic [15:0] old_word;
   logic [15:0] rd_word;
   logic pin_ready;
   logic pin_load_a;
   logic pin_load_b;

   // merge the two low byte lanes into an old 16-bit value
   function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                               input logic [31:0] wdata,
                                               input logic [3:0] strb);
      logic [15:0] res;
      res = old_v;
      if (strb[0]) begin
         res[7:0] = wdata[7:0]; // [R13]
      end
      if (strb[1]) begin
         res[15:8] = wdata[15:8]; // [R13]
      end
      return res;
   endfunction : merge_lanes

   // strobe pin synchroniser and edge detector
   duc_edge u_edge (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin_i(aux_strobe_pin_i),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   // converter code, enable and span outputs
   duc_code_hold u_hold (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .load_i(load_req),
      .code_i(load_code),
      .enable_i(next_st.enable),
      .span_i(next_st.span),
      .dac_code_o(dac_code_o),
      .dac_enable_o(dac_enable_o),
      .dac_span_o(dac_span_o)
   );

   // bus phase decode; a transfer commits in the cycle that shows ready
   assign access = psel_i & penable_i & st.pready;
   assign wr_now = access & pwrite_i;
   assign idx = paddr_i[ADDR_W-1:IDX_LSB];

   // register hits; an index outside the map answers with an error
   assign hit_span = (idx == IDX_SPAN);
   assign hit_enable = (idx == IDX_ENABLE);
   assign hit_tog_mask = (idx == IDX_TOG_MASK);
   assign hit_ld_mask = (idx == IDX_LD_MASK);
   assign hit_direct = (idx == IDX_DIRECT);
   assign hit_soft_alt = (idx == IDX_SOFT_ALT);
   assign hit_soft_ld = (idx == IDX_SOFT_LD);
   assign hit_stage_a = (idx == IDX_STAGE_A);
   assign hit_stage_b = (idx == IDX_STAGE_B);
   assign mapped = hit_span | hit_enable | hit_tog_mask | hit_ld_mask | hit_direct
                   | hit_soft_alt | hit_soft_ld | hit_stage_a | hit_stage_b;

   // one write strobe per register, only in the committing cycle
   // so a refused or still waiting transfer can never touch state
   assign wr_span = wr_now & hit_span;
   assign wr_enable = wr_now & hit_enable;
   assign wr_tog_mask = wr_now & hit_tog_mask;
   assign wr_ld_mask = wr_now & hit_ld_mask;
   assign wr_direct = wr_now & hit_direct;
   assign wr_soft_alt = wr_now & hit_soft_alt;
   assign wr_soft_ld = wr_now & hit_soft_ld;
   assign wr_stage_a = wr_now & hit_stage_a;
   assign wr_stage_b = wr_now & hit_stage_b;

   // address decode and read view of the addressed register
   always_comb begin
      old_word = REG_RESET;
      unique case (idx)
         IDX_SPAN: begin
            old_word[CTRL_BIT] = st.span;
         end
         IDX_ENABLE: begin
            old_word[CTRL_BIT] = st.enable;
         end
         IDX_TOG_MASK: begin
            old_word[CTRL_BIT] = st.tog_mask;
         end
         IDX_LD_MASK: begin
            old_word[CTRL_BIT] = st.ld_mask;
         end
         IDX_DIRECT: begin
            old_word[CODE_W-1:0] = st.direct;
         end
         IDX_SOFT_ALT: begin
            old_word[CTRL_BIT] = st.alt_sel;
         end
         IDX_SOFT_LD: begin
            old_word[CTRL_BIT] = st.soft_ld;
         end
         IDX_STAGE_A: begin
            old_word[CODE_W-1:0] = st.stage_a; // [R10]
         end
         IDX_STAGE_B: begin
            old_word[CODE_W-1:0] = st.stage_b; // [R11]
         end
         default: begin
            old_word = REG_RESET; // unmapped index reads as zero
         end
      endcase
      rd_word = old_word;
   end

   // write data with byte lanes applied; reserved bits are dropped later
   assign wr_word = merge_lanes(old_word, pwdata_i, pstrb_i);

   // pin events only act once the pin is handed to the converter
   assign pin_ready = aux_pin_function_sel_i; // [R5]
   always_comb begin
      pin_load_a = 1'b0;
      pin_load_b = 1'b0;
      if (pin_ready && st.tog_mask) begin
         pin_load_a = pin_fall; // [R3]
         pin_load_b = pin_rise; // [R3]
      end else if (pin_ready && st.ld_mask) begin
         pin_load_a = pin_fall; // [R6]
      end
      // with toggle on, the load branch above is never taken [R4]
   end

   // register updates and bus answer
   always_comb begin
      next_st = st;
      // one wait state: ready rises in the second access cycle
      next_st.pready = psel_i & penable_i & ~st.pready;
      next_st.pslverr = 1'b0;
      next_st.prdata = RDATA_IDLE;
      if (psel_i && penable_i && !st.pready) begin
         next_st.pslverr = ~mapped;
         if (!pwrite_i && mapped) begin
            next_st.prdata = {16'h0000, rd_word};
         end
      end
      // soft load completes one cycle after it was requested
      if (st.soft_ld) begin
         next_st.soft_ld = 1'b0; // [R9]
      end
      // each register takes its committed write; reserved bits are dropped
      if (wr_span) begin
         next_st.span = wr_word[CTRL_BIT]; // [R1]
      end
      if (wr_enable) begin
         next_st.enable = wr_word[CTRL_BIT]; // [R2]
      end
      if (wr_tog_mask) begin
         next_st.tog_mask = wr_word[CTRL_BIT]; // [R5]
      end
      if (wr_ld_mask) begin
         next_st.ld_mask = wr_word[CTRL_BIT]; // [R6]
      end
      if (wr_direct) begin
         next_st.direct = wr_word[CODE_W-1:0]; // [R7]
      end
      if (wr_soft_alt) begin
         next_st.alt_sel = wr_word[CTRL_BIT]; // [R8]
      end
      // a new request wins over the self-clear in the same cycle
      if (wr_soft_ld && wr_word[CTRL_BIT]) begin
         next_st.soft_ld = 1'b1; // [R9]
      end
      if (wr_stage_a) begin
         next_st.stage_a = wr_word[CODE_W-1:0]; // [R10]
      end
      if (wr_stage_b) begin
         next_st.stage_b = wr_word[CODE_W-1:0]; // [R11]
      end
   end

   // pick the load source; fixed priority: direct write, alternate select, soft load, rising pin, falling pin
   always_comb begin
      load_req = 1'b0;
      load_code = st.stage_a;
      if (wr_direct) begin
         load_req = 1'b1;
         load_code = wr_word[CODE_W-1:0]; // [R7]
      end else if (wr_soft_alt) begin
         load_req = 1'b1;
         load_code = wr_word[CTRL_BIT] ? st.stage_b : st.stage_a; // [R8]
      end else if (st.soft_ld) begin
         load_req = 1'b1;
         load_code = st.stage_a; // [R9]
      end else if (pin_load_b) begin
         load_req = 1'b1;
         load_code = st.stage_b; // [R11]
      end else if (pin_load_a) begin
         load_req = 1'b1;
         load_code = st.stage_a; // [R6]
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st <= '{span: 1'b0,
                 enable: 1'b0,
                 tog_mask: 1'b0,
                 ld_mask: 1'b0,
                 direct: CODE_RESET,
                 alt_sel: 1'b0,
                 soft_ld: 1'b0,
                 stage_a: CODE_RESET,
                 stage_b: CODE_RESET,
                 pready: 1'b0,
                 pslverr: 1'b0,
                 prdata: RDATA_IDLE}; // [R12]
      end else begin
         st <= next_st;
      end
   end

   // bus outputs come straight from the state register
   assign prdata_o = st.prdata;
   assign pready_o = st.pready;
   assign pslverr_o = st.pslverr;
endmodule : duc_top

/* hw/duc_pkg.sv */
package duc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_SPAN = 10'h150;
   localparam logic [9:0] IDX_ENABLE = 10'h152;
   localparam logic [9:0] IDX_TOG_MASK = 10'h154;
   localparam logic [9:0] IDX_LD_MASK = 10'h156;
   localparam logic [9:0] IDX_DIRECT = 10'h158;
   localparam logic [9:0] IDX_SOFT_ALT = 10'h168;
   localparam logic [9:0] IDX_SOFT_LD = 10'h16a;
   localparam logic [9:0] IDX_STAGE_A = 10'h16c;
   localparam logic [9:0] IDX_STAGE_B = 10'h17c;
   // bus and field layout
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int CODE_W = 12;
   localparam int CTRL_BIT = 0;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
   localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
   // register state of the top block
   typedef struct packed {
      logic span;
      logic enable;
      logic tog_mask;
      logic ld_mask;
      logic [CODE_W-1:0] direct;
      logic alt_sel;
      logic soft_ld;
      logic [CODE_W-1:0] stage_a;
      logic [CODE_W-1:0] stage_b;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } duc_regs_t;
   // strobe synchroniser state
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic rise;
      logic fall;
   } duc_edge_t;
   // converter output state
   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic enable;
      logic span;
   } duc_out_t;
endpackage : duc_pkg

/* hw/duc_edge.sv */
`timescale 1ns/1ns
module duc_edge
   import duc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // asynchronous strobe pin
   input wire logic pin_i,
   // one-cycle edge pulses
   output logic rise_o,
   output logic fall_o
);
   duc_edge_t st;
   duc_edge_t next_st;

   // two-flop synchroniser, then edge detection on the clean copy
   always_comb begin
      next_st = st;
      next_st.meta = pin_i;
      next_st.sync = st.meta;
      next_st.prev = st.sync;
      next_st.rise = st.sync & ~st.prev;
      next_st.fall = ~st.sync & st.prev;
   end

   // state register; pin idles high so no false edge after reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, rise: 1'b0, fall: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign rise_o = st.rise;
   assign fall_o = st.fall;
endmodule : duc_edge

/* hw/duc_code_hold.sv */
`timescale 1ns/1ns
module duc_code_hold
   import duc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // load request and settings
   input wire logic load_i,
   input wire logic [CODE_W-1:0] code_i,
   input wire logic enable_i,
   input wire logic span_i,
   // converter controls
   output logic [CODE_W-1:0] dac_code_o,
   output logic dac_enable_o,
   output logic dac_span_o
);
   duc_out_t st;
   duc_out_t next_st;

   // latest load wins; code kept while converter is off
   always_comb begin
      next_st = st;
      next_st.enable = enable_i;
      next_st.span = span_i;
      if (load_i) begin
         next_st.code = code_i; // [R14]
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st <= '{code: CODE_RESET, enable: 1'b0, span: 1'b0}; // [R12]
      end else begin
         st <= next_st;
      end
   end

   assign dac_code_o = st.code;
   assign dac_enable_o = st.enable;
   assign dac_span_o = st.span;
endmodule : duc_code_hold

/* tb/duc_aux_host.sv */
`timescale 1ns/1ns
module duc_aux_host (
   // requested strobe level
   input wire logic level_i,
   // strobe pin
   output logic pin_o
);
   // pin idles high so the synchroniser sees no edge at start-up
   initial pin_o = 1'b1;
   // host moves the pin off the clock grid, like an unrelated controller
   always @(level_i) pin_o <= #17 level_i;
endmodule : duc_aux_host

/* tb/duc_top_assertions.sv */
`timescale 1ns/1ns
module duc_top_assertions
   import duc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // converter controls
   input wire logic [CODE_W-1:0] dac_code_o,
   input wire logic dac_enable_o,
   input wire logic dac_span_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // committed write and its register index
   logic wr;
   logic [9:0] ix;
   assign wr = psel_i & penable_i & pready_o & pwrite_i & !pslverr_o;
   assign ix = paddr_i[11:2];
   reset_outs_a: assert property (disable iff (1'b0)
      !resetn_i |=> dac_code_o == '0 && !dac_enable_o && !dac_span_o)
      else $error("outputs not cleared by reset");
   ready_wait_a: assert property (psel_i && $rose(penable_i) |=> pready_o)
      else $error("ready not in second access cycle");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   err_data_a: assert property (pslverr_o |-> pready_o && prdata_o == '0)
      else $error("error without ready or with data");
   idle_data_a: assert property (!pready_o |-> prdata_o == '0)
      else $error("read data outside answer cycle");
   direct_load_a: assert property (wr && ix == IDX_DIRECT && pstrb_i[1:0] == 2'b11
      |=> ##1 dac_code_o == $past(pwdata_i[11:0], 2)) else $error("direct code not loaded");
   enable_follow_a: assert property (wr && ix == IDX_ENABLE && pstrb_i[0]
      |=> ##1 dac_enable_o == $past(pwdata_i[0], 2)) else $error("enable not followed");
   enable_cause_a: assert property ($changed(dac_enable_o)
      |-> $past(wr && ix == IDX_ENABLE)) else $error("enable moved without write");
   span_follow_a: assert property (wr && ix == IDX_SPAN && pstrb_i[0]
      |=> ##1 dac_span_o == $past(pwdata_i[0], 2)) else $error("span not followed");
   // main scenarios
   cover property (wr && ix == IDX_DIRECT);
   cover property (pslverr_o);
   cover property ($rose(dac_enable_o));
endmodule : duc_top_assertions
bind duc_top duc_top_assertions chk (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .dac_code_o,
   .dac_enable_o, .dac_span_o);

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top
   import duc_pkg::*;
();
   logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic lvl, pin, fsel, dac_enable_o, dac_span_o, er;
   logic [ADDR_W-1:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0] pstrb_i;
   logic [CODE_W-1:0] dac_code_o;
   int err_total = 0;
   int compares = 0;
   typedef struct packed {
      logic [9:0] ix;
      logic [15:0] d;
      logic [15:0] q;
   } duc_row_t;
   // register, written value, read-back value
   duc_row_t rows [0:7] = '{'{IDX_SPAN, 16'hffff, 16'h0001},
      '{IDX_ENABLE, 16'hffff, 16'h0001}, '{IDX_TOG_MASK, 16'hffff, 16'h0001},
      '{IDX_LD_MASK, 16'hffff, 16'h0001}, '{IDX_STAGE_A, 16'hffff, 16'h0fff},
      '{IDX_STAGE_B, 16'h0abc, 16'h0abc}, '{IDX_DIRECT, 16'hf123, 16'h0123},
      '{IDX_SOFT_ALT, 16'h0000, 16'h0000}};
   duc_top dut (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .aux_strobe_pin_i(pin),
      .aux_pin_function_sel_i(fsel), .dac_code_o, .dac_enable_o, .dac_span_o);
   duc_aux_host host (.level_i(lvl), .pin_o(pin));
   // verdict and end of run
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer, then an idle cycle
   task automatic apb(input logic w, input logic [9:0] ix, input logic [15:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {ix, 2'b00};
      pwdata_i <= {16'h0000, d};
      pstrb_i <= s;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20) begin
         err_total++;
         complete_run();
      end
      @(posedge clk_i);
   endtask : apb
   task automatic put(input logic [9:0] ix, input logic [15:0] d);
      apb(1'b1, ix, d, 4'h3);
   endtask : put
   task automatic code(input int n, input logic [11:0] e);
      repeat (n) @(posedge clk_i);
      chk(32'(dac_code_o), 32'(e));
   endtask : code
   // strobe level change, then the code seven edges after the level change
   task automatic strobe(input logic v, input logic [11:0] e);
      lvl <= v;
      code(7, e);
   endtask : strobe
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      {resetn_i, psel_i, penable_i, pwrite_i, fsel, paddr_i, pwdata_i, pstrb_i} = '0;
      lvl = 1'b1;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      foreach (rows[i]) begin
         put(rows[i].ix, rows[i].d);
         apb(1'b0, rows[i].ix, 16'h0, 4'h0);
         chk(rd, 32'(rows[i].q));
      end
      code(2, 12'hfff);
      chk(32'({dac_enable_o, dac_span_o}), 32'h3);
      $display("register table done");
      resetn_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      chk(32'({dac_code_o, dac_enable_o, dac_span_o}), 32'h0);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].ix, 16'h0, 4'h0);
         chk(rd, 32'h0);
      end
      $display("reset done");
      put(IDX_STAGE_A, 16'h0123);
      apb(1'b1, IDX_STAGE_A, 16'h0f45, 4'h1);
      apb(1'b1, IDX_STAGE_A, 16'h0a99, 4'h2);
      apb(1'b0, IDX_STAGE_A, 16'h0, 4'h0);
      chk(rd, 32'h0a45);
      put(IDX_SOFT_LD, 16'h0001);
      code(2, 12'ha45);
      apb(1'b0, IDX_SOFT_LD, 16'h0, 4'h0);
      chk(rd, 32'h0);
      put(IDX_STAGE_B, 16'h0bcd);
      put(IDX_SOFT_ALT, 16'h0001);
      code(2, 12'hbcd);
      put(IDX_DIRECT, 16'h0777);
      code(2, 12'h777);
      $display("software loads done");
      put(IDX_TOG_MASK, 16'h0001);
      strobe(1'b0, 12'h777);
      strobe(1'b1, 12'h777);
      fsel <= 1'b1;
      strobe(1'b0, 12'ha45);
      strobe(1'b1, 12'hbcd);
      put(IDX_LD_MASK, 16'h0001);
      strobe(1'b0, 12'ha45);
      strobe(1'b1, 12'hbcd);
      put(IDX_TOG_MASK, 16'h0000);
      strobe(1'b0, 12'ha45);
      strobe(1'b1, 12'ha45);
      $display("pin loads done");
      put(IDX_ENABLE, 16'h0000);
      code(2, 12'ha45);
      chk(32'(dac_enable_o), 32'h0);
      apb(1'b0, 10'h151, 16'h0, 4'h0);
      chk({rd[30:0], er}, 32'h1);
      $display("disable and error done");
      complete_run();
   end
endmodule : tb_top
